// [dsh_pkg.sv]
// shared constants and types of the dual serial host interface
package dsh_pkg;

   // serial frame geometry
   localparam int FRAME_BITS = 24;
   localparam logic [4:0] FRAME_LAST = 5'h17;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // register space reached by both protocols
   localparam int REG_COUNT = 128;
   localparam logic [15:0] REG_RESET = 16'h0000;

   // interface configuration register and its fields
   localparam logic [6:0] IFCFG_ADDR = 7'h1F;
   localparam int OUT_EN_BIT = 0;
   localparam int OUT_EDGE_BIT = 1;

   // two-wire target addressing
   localparam logic [3:0] I2C_ADDR_HI = 4'h9;
   localparam logic [6:0] BCAST_ADDR = 7'h47;
   localparam logic [7:0] GCALL_BYTE = 8'h00;
   localparam logic [7:0] GCALL_RESET = 8'h06;
   localparam logic [2:0] STRAP_GND = 3'h0;
   localparam logic [2:0] STRAP_VDD = 3'h1;
   localparam logic [2:0] STRAP_SDA = 3'h2;
   localparam logic [2:0] STRAP_SCL = 3'h3;

   // which protocol owns the device since power-up
   typedef enum logic [2:0]
   {
      DSH_NONE = 3'h1,
      DSH_SPI = 3'h2,
      DSH_I2C = 3'h4
   } dsh_mode_t;

   // two-wire target sequencer
   typedef enum logic [5:0]
   {
      I_IDLE = 6'h01,
      I_ADDR = 6'h02,
      I_ACK = 6'h04,
      I_RX = 6'h08,
      I_TX = 6'h10,
      I_TACK = 6'h20
   } dsh_i2c_t;

endpackage

// [dsh_sync.sv]
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ns
`default_nettype none
module dsh_sync
#(
   parameter int WIDTH = 4
)
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   typedef struct packed
   {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] held;
   } dsh_sync_t;

   dsh_sync_t st;
   dsh_sync_t next_st;

   // first stage feeds only the second stage
   always_comb
   begin
      next_st.meta = d;
      next_st.held = st.meta;
   end

   // reset to the idle-high pin level so no false edge follows reset
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         st <= '1;
      else
         st <= next_st;
   end

   assign q = st.held;

endmodule // dsh_sync
`default_nettype wire

// [dsh_spi_link.sv]
// serial-clock side of the spi slave: shifting, edge counting, output launch
`timescale 1ns/1ns
`default_nettype none
module dsh_spi_link
(
   input wire logic sclk,
   input wire logic nrst,
   input wire logic sync_n,
   input wire logic sdi,
   input wire logic four_wire,
   input wire logic out_edge_select,
   input wire logic [23:0] resp,
   output logic [23:0] shift_word,
   output logic [23:0] first_word,
   output logic [4:0] edge_mod,
   output logic full_frame,
   output logic sdo,
   output logic sdo_oe
);

   typedef struct packed
   {
      logic [23:0] sr;
      logic [23:0] first;
      logic [4:0] cnt;
      logic ge24;
   } dsh_link_t;

   dsh_link_t st;
   dsh_link_t next_st;
   logic fresh;
   logic out_r;

   // sample on falling edges; the echo word is preloaded so it leaves first
   always_comb
   begin
      next_st = st;
      if (!sync_n)
      begin
         if (fresh)
         begin
            next_st.sr = {resp[22:0], sdi};
            next_st.cnt = 5'h01;
            next_st.ge24 = 1'b0;
         end
         else
         begin
            next_st.sr = {st.sr[22:0], sdi};
            if (st.cnt == dsh_pkg::FRAME_LAST)
            begin
               next_st.cnt = 5'h00;
               next_st.ge24 = 1'b1;
               if (!st.ge24)
                  next_st.first = {st.sr[22:0], sdi};
            end
            else
               next_st.cnt = st.cnt + 5'h01;
         end
      end
   end

   always_ff @(negedge sclk or negedge nrst)
   begin
      if (!nrst)
         st <= '0;
      else
         st <= next_st;
   end

   // marks the first edge of a frame; preset while the frame select is high
   always_ff @(negedge sclk or posedge sync_n)
   begin
      if (sync_n)
         fresh <= 1'b1;
      else
         fresh <= 1'b0;
   end

   // rising-edge launch holds each bit across the falling sample edge
   always_ff @(posedge sclk or negedge nrst)
   begin
      if (!nrst)
         out_r <= 1'b0;
      else if (!sync_n)
         out_r <= st.sr[23];
   end

   // counts stay frozen while the frame select is high, so the other domain reads them then
   assign shift_word = st.sr;
   assign first_word = st.first;
   assign edge_mod = st.cnt;
   assign full_frame = st.ge24;
   assign sdo = fresh ? resp[23] : (out_edge_select ? out_r : st.sr[23]);
   assign sdo_oe = !sync_n && four_wire;

endmodule // dsh_spi_link
`default_nettype wire

// [dsh_host_if.sv]
// top of the dual serial host interface: protocol lock, register space, spi frame
// decode and the two-wire target
//
// Notes on behaviour
// - first protocol seen after power-up wins
// - other protocol ignored until power cycle; under two-wire lock sdo still drives during four-wire frames
// - four-wire only when pin is serial output
// - sample input on falling serial clock edges
// - frames under 24 edges are dropped
// - three-wire uses first 24 bits only
// - idle frame select blocks clock, floats output
// - reads need output enable bit set
// - second frame shifts out requested data
// - echo previous direction and address on output
// - output edge chosen by configuration bit
// - daisy chain uses last 24 bits
// - four-wire drops non-multiple-of-24 frames
// - output forwards earlier bits down the chain
// - two-wire target acknowledges, receives, transmits
// - same protocol at 100k, 400k, 1M rates
// - seven-bit addressing only
// - general call 0x06 triggers software reset
// - ninth clock carries acknowledge, low means ack
// - address 1001 plus strapped low bits
// - write is address, command, upper, lower
`timescale 1ns/1ns
`default_nettype none
module dsh_host_if
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   input wire logic gpio_is_sdo,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_strap_pin,
   output logic wr_valid,
   output logic [6:0] wr_addr,
   output logic [15:0] wr_data,
   output logic soft_reset,
   output logic frame_dropped,
   output logic read_ignored,
   output logic [2:0] iface_mode,
   output logic serial_out_enable,
   output logic out_edge_select
);

   typedef struct packed
   {
      dsh_pkg::dsh_mode_t mode;
      dsh_pkg::dsh_i2c_t ist;
      logic [dsh_pkg::REG_COUNT-1:0][15:0] regs;
      logic out_en;
      logic out_edge;
      logic [23:0] resp;
      logic sync_prev;
      logic scl_prev;
      logic sda_prev;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic [1:0] byte_n;
      logic rnw;
      logic gcall;
      logic gc_rst;
      logic pend_wr;
      logic nack;
      logic [6:0] ptr;
      logic [7:0] upper_data_byte;
      logic [3:0] txi;
      logic diff_scl;
      logic diff_sda;
      logic lvl;
      logic sda_oe;
      logic wr_valid;
      logic [6:0] wr_addr;
      logic [15:0] wr_data;
      logic soft_reset;
      logic frame_dropped;
      logic read_ignored;
   } dsh_top_t;

   // edge detectors start at the idle-high pin level, matching the synchroniser reset
   localparam dsh_top_t TOP_RESET = '{mode: dsh_pkg::DSH_NONE, ist: dsh_pkg::I_IDLE,
      sync_prev: 1'b1, scl_prev: 1'b1, sda_prev: 1'b1, default: '0};

   dsh_top_t st;
   dsh_top_t next_st;

   logic [3:0] pins_s;
   logic sync_s;
   logic scl_s;
   logic sda_s;
   logic strap_s;
   logic [23:0] shift_word;
   logic [23:0] first_word;
   logic [4:0] edge_mod;
   logic full_frame;
   logic four_wire;

   // frame select, bus lines and strap pass two flip-flops; sclk, sdi, gpio_is_sdo and the link's sync_n are used directly
   dsh_sync #(.WIDTH(4)) u_sync
   (
      .clock(clock),
      .nrst(nrst),
      .d({sync_n, scl_in, sda_in, addr_strap_pin}),
      .q(pins_s)
   );

   assign sync_s = pins_s[3];
   assign scl_s = pins_s[2];
   assign sda_s = pins_s[1];
   assign strap_s = pins_s[0];

   // four-wire needs both the enable bit and the pin mapped as output
   assign four_wire = st.out_en && gpio_is_sdo;

   // the link side; echo word and spi-written config only change while frame select is high, two-wire writes and soft reset at any time
   dsh_spi_link u_link
   (
      .sclk(sclk),
      .nrst(nrst),
      .sync_n(sync_n),
      .sdi(sdi),
      .four_wire(four_wire),
      .out_edge_select(st.out_edge),
      .resp(st.resp),
      .shift_word(shift_word),
      .first_word(first_word),
      .edge_mod(edge_mod),
      .full_frame(full_frame),
      .sdo(sdo),
      .sdo_oe(sdo_oe)
   );

   // all protocol decisions of the system clock domain
   always_comb
   begin
      logic do_wr;
      logic [6:0] w_addr;
      logic [15:0] w_data;
      logic start;
      logic stop;
      logic rise;
      logic fall;
      logic [2:0] strap;
      logic [15:0] tx_word;
      logic [3:0] nidx;
      logic match;
      logic [23:0] word;
      do_wr = 1'b0;
      w_addr = 7'h00;
      w_data = 16'h0000;
      start = scl_s && st.scl_prev && st.sda_prev && !sda_s;
      stop = scl_s && st.scl_prev && !st.sda_prev && sda_s;
      rise = scl_s && !st.scl_prev;
      fall = !scl_s && st.scl_prev;
      tx_word = st.regs[st.ptr];
      nidx = st.txi + 4'h1;
      match = 1'b0;
      word = four_wire ? shift_word : first_word;
      if (!st.diff_scl)
         strap = dsh_pkg::STRAP_SCL;
      else if (!st.diff_sda)
         strap = dsh_pkg::STRAP_SDA;
      else if (st.lvl)
         strap = dsh_pkg::STRAP_VDD;
      else
         strap = dsh_pkg::STRAP_GND;

      next_st = st;
      next_st.sync_prev = sync_s;
      next_st.scl_prev = scl_s;
      next_st.sda_prev = sda_s;
      next_st.wr_valid = 1'b0;
      next_st.soft_reset = 1'b0;
      next_st.frame_dropped = 1'b0;
      next_st.read_ignored = 1'b0;

      // end of an spi frame: link counters are frozen now
      if (sync_s && !st.sync_prev && st.mode != dsh_pkg::DSH_I2C)
      begin
         if (full_frame && (!four_wire || edge_mod == 5'h00))
         begin
            next_st.mode = dsh_pkg::DSH_SPI;
            if (!word[23])
            begin
               do_wr = 1'b1;
               w_addr = word[22:16];
               w_data = word[15:0];
               next_st.resp = word;
            end
            else if (four_wire)
               next_st.resp = {word[23:16], st.regs[word[22:16]]};
            else
            begin
               next_st.resp = {word[23:16], 16'h0000};
               next_st.read_ignored = 1'b1;
            end
         end
         else
            next_st.frame_dropped = 1'b1;
      end

      // two-wire target, idle for good once spi owns the device
      if (st.mode != dsh_pkg::DSH_SPI)
      begin
         case (st.ist)
            dsh_pkg::I_IDLE:
            begin
               next_st.sda_oe = 1'b0;
            end
            dsh_pkg::I_ADDR:
            begin
               // the strap may be tied to a rail or to either bus line
               next_st.diff_scl = st.diff_scl | (strap_s ^ scl_s);
               next_st.diff_sda = st.diff_sda | (strap_s ^ sda_s);
               next_st.lvl = strap_s;
               if (rise)
               begin
                  next_st.sh = {st.sh[6:0], sda_s};
                  next_st.bitc = st.bitc + 4'h1;
               end
               if (fall && st.bitc == dsh_pkg::BYTE_BITS)
               begin
                  // fixed upper bits rule out ten-bit prefixes
                  match = (st.sh[7:1] == {dsh_pkg::I2C_ADDR_HI, strap})
                     || (st.sh[7:1] == dsh_pkg::BCAST_ADDR && !st.sh[0])
                     || (st.sh == dsh_pkg::GCALL_BYTE);
                  if (match)
                  begin
                     next_st.sda_oe = 1'b1;
                     next_st.ist = dsh_pkg::I_ACK;
                     next_st.rnw = st.sh[0];
                     next_st.gcall = (st.sh == dsh_pkg::GCALL_BYTE);
                     next_st.bitc = 4'h0;
                     if (st.mode == dsh_pkg::DSH_NONE)
                        next_st.mode = dsh_pkg::DSH_I2C;
                  end
                  else
                     next_st.ist = dsh_pkg::I_IDLE;
               end
            end
            dsh_pkg::I_ACK:
            begin
               if (rise && st.gc_rst)
               begin
                  next_st.soft_reset = 1'b1;
                  next_st.gc_rst = 1'b0;
               end
               if (fall)
               begin
                  next_st.bitc = 4'h0;
                  if (st.pend_wr)
                  begin
                     // update lands on the falling edge that ends the lower byte's acknowledge clock
                     do_wr = 1'b1;
                     w_addr = st.ptr;
                     w_data = st.wr_data;
                     next_st.pend_wr = 1'b0;
                  end
                  if (st.rnw && !st.gcall)
                  begin
                     next_st.ist = dsh_pkg::I_TX;
                     next_st.txi = 4'h0;
                     next_st.sda_oe = !tx_word[15];
                  end
                  else
                  begin
                     next_st.ist = dsh_pkg::I_RX;
                     next_st.sda_oe = 1'b0;
                  end
               end
            end
            dsh_pkg::I_RX:
            begin
               if (rise)
               begin
                  next_st.sh = {st.sh[6:0], sda_s};
                  next_st.bitc = st.bitc + 4'h1;
               end
               if (fall && st.bitc == dsh_pkg::BYTE_BITS)
               begin
                  next_st.bitc = 4'h0;
                  next_st.ist = dsh_pkg::I_ACK;
                  next_st.sda_oe = 1'b1;
                  if (st.gcall)
                     next_st.gc_rst = (st.sh == dsh_pkg::GCALL_RESET);
                  else
                  begin
                     case (st.byte_n)
                        2'h0:
                        begin
                           next_st.ptr = st.sh[6:0];
                           next_st.byte_n = 2'h1;
                        end
                        2'h1:
                        begin
                           next_st.upper_data_byte = st.sh;
                           next_st.byte_n = 2'h2;
                        end
                        default:
                        begin
                           next_st.wr_data = {st.upper_data_byte, st.sh};
                           next_st.pend_wr = 1'b1;
                           next_st.byte_n = 2'h1;
                        end
                     endcase
                  end
               end
            end
            dsh_pkg::I_TX:
            begin
               if (fall)
               begin
                  next_st.txi = nidx;
                  if (st.txi[2:0] == 3'h7)
                  begin
                     next_st.sda_oe = 1'b0;
                     next_st.ist = dsh_pkg::I_TACK;
                  end
                  else
                     next_st.sda_oe = !tx_word[4'hF - nidx];
               end
            end
            dsh_pkg::I_TACK:
            begin
               if (rise)
                  next_st.nack = sda_s;
               if (fall)
               begin
                  if (st.nack)
                     next_st.ist = dsh_pkg::I_IDLE;
                  else
                  begin
                     next_st.ist = dsh_pkg::I_TX;
                     next_st.sda_oe = !tx_word[4'hF - st.txi];
                  end
               end
            end
            default:
            begin
               next_st.ist = dsh_pkg::I_IDLE;
               next_st.sda_oe = 1'b0;
            end
         endcase

         // bus conditions override every state; timing is rate independent
         if (start)
         begin
            next_st.ist = dsh_pkg::I_ADDR;
            next_st.bitc = 4'h0;
            next_st.byte_n = 2'h0;
            next_st.gcall = 1'b0;
            next_st.gc_rst = 1'b0;
            next_st.pend_wr = 1'b0;
            next_st.sda_oe = 1'b0;
            next_st.diff_scl = 1'b0;
            next_st.diff_sda = 1'b0;
         end
         else if (stop)
         begin
            next_st.ist = dsh_pkg::I_IDLE;
            next_st.sda_oe = 1'b0;
         end
      end

      // single write port shared by both protocols
      if (do_wr)
      begin
         next_st.regs[w_addr] = w_data;
         next_st.wr_valid = 1'b1;
         next_st.wr_addr = w_addr;
         next_st.wr_data = w_data;
         if (w_addr == dsh_pkg::IFCFG_ADDR)
         begin
            next_st.out_en = w_data[dsh_pkg::OUT_EN_BIT];
            next_st.out_edge = w_data[dsh_pkg::OUT_EDGE_BIT];
         end
      end

      // software reset restores register defaults but keeps the protocol lock
      if (next_st.soft_reset)
      begin
         for (int i = 0; i < dsh_pkg::REG_COUNT; i++)
            next_st.regs[i] = dsh_pkg::REG_RESET;
         next_st.out_en = 1'b0;
         next_st.out_edge = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         st <= TOP_RESET;
      else
         st <= next_st;
   end

   // outputs straight from state, except sda_out which is tied low
   assign sda_out = 1'b0;
   assign sda_oe = st.sda_oe;
   assign wr_valid = st.wr_valid;
   assign wr_addr = st.wr_addr;
   assign wr_data = st.wr_data;
   assign soft_reset = st.soft_reset;
   assign frame_dropped = st.frame_dropped;
   assign read_ignored = st.read_ignored;
   assign iface_mode = st.mode;
   assign serial_out_enable = st.out_en;
   assign out_edge_select = st.out_edge;

endmodule // dsh_host_if
`default_nettype wire

// [dsh_host_if_monitor.sv]
// assertion checker bound to the dual serial host interface top
`timescale 1ns/1ns
`default_nettype none
module dsh_host_if_monitor
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic gpio_is_sdo,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic addr_strap_pin,
   input wire logic wr_valid,
   input wire logic [6:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic soft_reset,
   input wire logic frame_dropped,
   input wire logic read_ignored,
   input wire logic [2:0] iface_mode,
   input wire logic serial_out_enable,
   input wire logic out_edge_select
);
   // link activity is judged through its results in the system clock domain
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);

   a_idle_floats: assert property (sync_n |-> !sdo_oe)
      else $error("output driven while frame select idle");
   a_out_needs_pin: assert property (sdo_oe |-> gpio_is_sdo && serial_out_enable)
      else $error("output driven without four-wire setup");
   a_read_needs_enable: assert property (read_ignored |-> !(gpio_is_sdo && serial_out_enable))
      else $error("read refused while four-wire active");
   a_mode_onehot: assert property ($onehot(iface_mode))
      else $error("protocol mode not one-hot");
   a_mode_locks: assert property (iface_mode != dsh_pkg::DSH_NONE |=> $stable(iface_mode))
      else $error("protocol lock changed");
   a_spi_mutes_i2c: assert property (iface_mode == dsh_pkg::DSH_SPI |-> !sda_oe)
      else $error("two-wire answer while spi locked");
   a_i2c_mutes_spi: assert property (iface_mode == dsh_pkg::DSH_I2C |-> !frame_dropped && !read_ignored)
      else $error("spi activity while two-wire locked");
   a_write_after_frame: assert property ((wr_valid && iface_mode != dsh_pkg::DSH_I2C)
      |-> sync_n && $past(sync_n, 2))
      else $error("spi write before frame ended");
   a_drop_no_write: assert property (frame_dropped |-> !wr_valid ##1 !frame_dropped)
      else $error("dropped frame wrote or pulse too long");
   a_cfg_update: assert property ((wr_valid && wr_addr == dsh_pkg::IFCFG_ADDR) |-> ##[1:2]
      (serial_out_enable == wr_data[0] && out_edge_select == wr_data[1]))
      else $error("configuration bits not updated");
   a_gcall_clears: assert property (soft_reset |-> ##2 (!serial_out_enable && !out_edge_select))
      else $error("soft reset left configuration set");
endmodule // dsh_host_if_monitor

bind dsh_host_if dsh_host_if_monitor mon (.clock, .nrst, .sclk, .sync_n, .sdi, .sdo, .sdo_oe,
   .gpio_is_sdo, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_strap_pin, .wr_valid, .wr_addr,
   .wr_data, .soft_reset, .frame_dropped, .read_ignored, .iface_mode, .serial_out_enable,
   .out_edge_select);
`default_nettype wire

// [dsh_host_model.sv]
// spi host model: gated serial clock, frame select and serial input
`timescale 1ns/1ns
`default_nettype none
module dsh_host_model
(
   output logic sclk,
   output logic sync_n,
   output logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe
);
   // clock stands high outside frames
   initial
   begin
      sclk = 1'b1;
      sync_n = 1'b1;
      sdi = 1'b0;
   end

   // n edges, msb first; output sampled just before each fall, valid for either launch edge
   task automatic frame(input logic [47:0] bits, input int n, output logic [47:0] got);
      got = '0;
      #7;
      sync_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         sdi = bits[n - 1 - i];
         #16;
         got = {got[46:0], sdo_oe ? sdo : 1'bz};
         sclk = 1'b0;
         #16;
         sclk = 1'b1;
      end
      #16;
      sync_n = 1'b1;
      sdi = ~sdi; // released line does not keep its last value
   endtask
endmodule // dsh_host_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the dual serial host interface
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic gpio_is_sdo = 1'b0;
   logic scl_in = 1'b1;
   logic sda_ctl = 1'b1;
   logic addr_strap_pin = 1'b0;
   wire logic sclk, sync_n, sdi, sdo, sdo_oe, sda_in, sda_out, sda_oe, wr_valid, soft_reset;
   wire logic frame_dropped, read_ignored, serial_out_enable, out_edge_select;
   wire logic [6:0] wr_addr;
   wire logic [15:0] wr_data;
   wire logic [2:0] iface_mode;
   logic [3:0] nw = 4'h0, nd = 4'h0, nr = 4'h0, ns = 4'h0;
   logic [47:0] got;
   logic [3:0] acks;
   logic [3:0] cack = 4'h0;
   logic [31:0] rd = 32'h0;
   int mismatches = 0;
   int total_checks = 0;
   // counts, last write, mode and configuration packed for one-line compares
   wire logic [47:0] st = {nw, nd, nr, ns, 1'b0, wr_addr, wr_data, 1'b0, iface_mode, 2'b00,
      out_edge_select, serial_out_enable};

   // open-drain data line with pull-up
   assign sda_in = sda_ctl & ~(sda_oe & ~sda_out);
   always #10 clock = ~clock;

   dsh_host_if uut (.clock, .nrst, .sclk, .sync_n, .sdi, .sdo, .sdo_oe, .gpio_is_sdo, .scl_in,
      .sda_in, .sda_out, .sda_oe, .addr_strap_pin, .wr_valid, .wr_addr, .wr_data, .soft_reset,
      .frame_dropped, .read_ignored, .iface_mode, .serial_out_enable, .out_edge_select);
   dsh_host_model host (.sclk, .sync_n, .sdi, .sdo, .sdo_oe);

   // pulse counters
   always @(posedge clock)
   begin
      if (wr_valid === 1'b1) nw <= nw + 4'h1;
      if (frame_dropped === 1'b1) nd <= nd + 4'h1;
      if (read_ignored === 1'b1) nr <= nr + 4'h1;
      if (soft_reset === 1'b1) ns <= ns + 4'h1;
   end

   task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] act);
      total_checks++;
      if (act !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, act);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // frame then a gap long enough for the result pulses to land
   task automatic spi(input logic [47:0] b, input int n);
      host.frame(b, n, got);
      repeat (10) @(negedge clock);
   endtask

   // one third of a two-wire bit, about 1 Mbps
   task automatic sq(input logic c, input logic d);
      repeat (17) @(negedge clock);
      scl_in = c;
      sda_ctl = d;
   endtask

   // start, n bytes msb first with acknowledge sampled in the ninth clock, stop
   task automatic xfer(input logic [31:0] b, input int n);
      acks = 4'h0;
      sq(1'b1, 1'b1);
      sq(1'b1, 1'b0);
      for (int k = 0; k < n; k++)
      begin
         for (int i = 0; i < 9; i++)
         begin
            sq(1'b0, sda_ctl);
            sq(1'b0, (i < 8) ? b[31 - 8 * k - i] : ~cack[3 - k]);
            sq(1'b1, sda_ctl);
            if (i < 8) rd = {rd[30:0], sda_in};
         end
         repeat (6) @(negedge clock);
         acks = {acks[2:0], ~sda_in};
      end
      sq(1'b0, sda_ctl);
      sq(1'b0, 1'b0);
      sq(1'b1, 1'b0);
      sq(1'b1, 1'b1);
      repeat (10) @(negedge clock);
   endtask

   // hang guard
   initial
   begin
      repeat (50000) @(posedge clock);
      mismatches++;
      results();
   end

   initial
   begin
      repeat (4) @(negedge clock);
      nrst = 1'b1;
      repeat (4) @(negedge clock);
      spi(48'h1F0001, 24);
      chk("lock_write", 48'h10001F000121, st);
      xfer(32'h90000000, 1);
      chk("i2c_after_spi", 48'h0, 48'(acks));
      spi(48'h7FFFFF, 23);
      chk("short", 48'h11001F000121, st);
      spi({18'h0, 24'h050123, 6'h2A}, 30);
      chk("long_3w", 48'h210005012321, st);
      spi(48'h850000, 24);
      chk("read_3w", 48'h211005012321, st);
      gpio_is_sdo = 1'b1;
      spi(48'h05ABCD, 24);
      chk("write_4w", 48'h311005ABCD21, st);
      spi(48'h850000, 24);
      chk("echo_write", 48'h05ABCD, 48'(got[23:0]));
      spi(48'h000000, 24);
      chk("read_data", 48'h85ABCD, 48'(got[23:0]));
      spi({24'h123456, 24'h064321}, 48);
      chk("chain_out", 48'h000000123456, got);
      chk("chain_last", 48'h511006432121, st);
      spi(48'h1FFFFFF, 25);
      chk("odd_4w", 48'h521006432121, st);
      spi(48'h1F0003, 24);
      spi(48'h000000, 24);
      chk("rise_edge", 48'h1F0003, 48'(got[23:0]));
      chk("cfg", 48'h721000000023, st);
      // power cycle, then let the two-wire side win the lock
      nrst = 1'b0;
      repeat (4) @(negedge clock);
      chk("por", 48'h721000000010, st);
      nrst = 1'b1;
      repeat (4) @(negedge clock);
      xfer({8'h90, 8'h1F, 8'h00, 8'h03}, 4);
      chk("i2c_acks", 48'hF, 48'(acks));
      chk("i2c_write", 48'h82101F000343, st);
      spi(48'h1F0000, 24);
      chk("spi_after_i2c", 48'h82101F000343, st);
      // set the pointer, then read it back; controller acks the upper byte only
      xfer({8'h90, 8'h1F, 16'h0}, 2);
      cack = 4'h4;
      xfer({8'h91, 16'hFFFF, 8'h0}, 3);
      cack = 4'h0;
      chk("i2c_read", 48'h910003, 48'(rd[23:0]));
      chk("i2c_rd_acks", 48'h6, 48'(acks));
      xfer({8'h00, 8'h06, 16'h0}, 2);
      chk("gcall_acks", 48'h3, 48'(acks));
      chk("gcall", 48'h821140, 48'({st[47:32], st[7:0]}));
      xfer(32'h92000000, 1);
      chk("other_addr", 48'h0, 48'(acks));
      xfer(32'hF0000000, 1);
      chk("ten_bit", 48'h0, 48'(acks));
      results();
   end
endmodule // tb_top
`default_nettype wire
